// ===== design/ctc_pkg.sv
/*
 * Shared constants and carrier types for the circular trigger capture
 * block. Assumes a single 100 MHz clock domain.
 */
package ctc_pkg;

    localparam int CTC_DEPTH = 10000;
    localparam int CTC_AW = 14;
    localparam int CTC_DW = 16;
    localparam int CTC_CW = 14;
    localparam logic [CTC_AW-1:0] CTC_ADDR_ZERO = 14'h0000;
    localparam logic [CTC_AW-1:0] CTC_ADDR_LAST = 14'h270F;
    localparam logic [CTC_CW-1:0] CTC_POST_RESET = 14'h0000;

    typedef enum logic [3:0] {
        CTC_IDLE = 4'b0001,
        CTC_PRE = 4'b0010,
        CTC_POST = 4'b0100,
        CTC_XFER = 4'b1000
    } ctc_state_t;

    typedef struct packed {
        logic [CTC_AW-1:0] trig_addr;
        logic [CTC_AW-1:0] end_addr;
        logic [CTC_AW-1:0] start_addr;
        logic wrapped;
    } ctc_record_t;

    typedef struct packed {
        logic valid;
        logic [CTC_DW-1:0] data;
    } ctc_sample_t;

endpackage : ctc_pkg

// ===== design/ctc_cell_mem.sv
/*
 * Sample memory for the capture block: one write port, one read port,
 * read data registered. Assumes the caller keeps addresses below DEPTH.
 */
`timescale 1ns/1ns
module ctc_cell_mem #(
    parameter int DEPTH = 10000,
    parameter int AW = 14,
    parameter int DW = 16
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:DEPTH-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule : ctc_cell_mem

// ===== design/ctc_capture.sv
/*
 * Acquisition control: circular capture into the ctc_cell_mem
 * model, trigger bookkeeping, host access gating and a simple DMA
 * master that streams the finished record out in time order.
 * Assumes all inputs are synchronous to i_clk and the host command
 * and length ports are pulses/levels from a register block elsewhere.
 */
// Operation
// - Capture command sets the busy flag.
// - Host memory access refused while busy.
// - Address counter clears to zero at start.
// - Samples stored indefinitely before trigger.
// - Exactly programmed post-trigger points stored.
// - After post count: stop, clear busy.
// - Write address wraps past last location.
// - Trigger records current write address.
// - Record end address; start is next.
// - DMA moves record without processor help.
// - Depth ten thousand points, counters wrap.
`timescale 1ns/1ns
module ctc_capture
    import ctc_pkg::*;
#(
    parameter int DEPTH = CTC_DEPTH,
    parameter int AW = CTC_AW,
    parameter int DW = CTC_DW,
    parameter int CW = CTC_CW
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start_capture,
    input wire logic [CW-1:0] i_post_count,
    input wire ctc_sample_t i_sample,
    input wire logic i_trigger,
    input wire logic i_host_rd,
    input wire logic [AW-1:0] i_host_addr,
    output logic o_host_ack,
    output logic o_host_refused,
    output logic [DW-1:0] o_host_rdata,
    input wire logic i_dma_start,
    input wire logic i_dma_ready,
    output logic o_dma_valid,
    output logic [DW-1:0] o_dma_data,
    output logic o_dma_last,
    output logic o_dma_busy,
    output logic o_busy,
    output logic o_triggered,
    output ctc_record_t o_record
);
    ctc_state_t state_r;
    logic [AW-1:0] waddr_r;
    logic [CW-1:0] post_left_r;
    logic [CW-1:0] post_count_r;
    ctc_record_t rec_r;
    logic [AW-1:0] dma_addr_r;
    logic [AW-1:0] dma_left_r;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    logic rd_pend_r;
    logic dma_pend_r;
    logic dma_have_r;
    logic dma_last_pend_r;
    logic we;
    logic host_ok;
    logic dma_issue;

    // Address increment shared by the write and DMA counters.
    function automatic logic [AW-1:0] ctc_next(input logic [AW-1:0] a);
        if (a == CTC_ADDR_LAST) begin
            ctc_next = CTC_ADDR_ZERO;
        end else begin
            ctc_next = a + 1'b1;
        end
    endfunction : ctc_next

    // Steps from the first address to the second around the ring, not inclusive.
    function automatic logic [AW-1:0] ctc_span(input logic [AW-1:0] a,
                                               input logic [AW-1:0] b);
        if (b >= a) begin
            ctc_span = b - a;
        end else begin
            ctc_span = AW'(DEPTH) - a + b;
        end
    endfunction : ctc_span

    assign we = i_sample.valid &&
                (state_r == CTC_PRE || state_r == CTC_POST);
    // A zero post count stops right on the trigger sample.
    assign host_ok = (state_r == CTC_IDLE);
    assign dma_issue = (state_r == CTC_XFER) && (dma_left_r != '0) &&
                       !dma_pend_r && (!dma_have_r || i_dma_ready);
    assign raddr = (state_r == CTC_XFER) ? dma_addr_r : i_host_addr;

    ctc_cell_mem #(
        .DEPTH(DEPTH),
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .i_clk(i_clk),
        .i_we(we),
        .i_waddr(waddr_r),
        .i_wdata(i_sample.data),
        .i_raddr(raddr),
        .o_rdata(rdata)
    );

    // Acquisition sequencing.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= CTC_IDLE;
        end else begin
            case (state_r)
                CTC_IDLE: begin
                    if (i_start_capture) begin
                        state_r <= CTC_PRE;
                    end else if (i_dma_start) begin
                        state_r <= CTC_XFER;
                    end
                end
                CTC_PRE: begin
                    if (we && i_trigger) begin
                        if (post_count_r == '0) begin
                            state_r <= CTC_IDLE;
                        end else begin
                            state_r <= CTC_POST;
                        end
                    end
                end
                CTC_POST: begin
                    if (we && post_left_r == CW'(1)) begin
                        state_r <= CTC_IDLE;
                    end
                end
                CTC_XFER: begin
                    if (dma_left_r == '0 && !dma_pend_r && !dma_have_r) begin
                        state_r <= CTC_IDLE;
                    end
                end
                default: state_r <= CTC_IDLE;
            endcase
        end
    end

    // Write address: cleared on command, steps per stored point.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            waddr_r <= CTC_ADDR_ZERO;
        end else if (state_r == CTC_IDLE && i_start_capture) begin
            waddr_r <= CTC_ADDR_ZERO;
        end else if (we) begin
            waddr_r <= ctc_next(waddr_r);
        end
    end

    // Post-trigger length is latched when capture starts.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            post_count_r <= CTC_POST_RESET;
            post_left_r <= CTC_POST_RESET;
        end else if (state_r == CTC_IDLE && i_start_capture) begin
            post_count_r <= i_post_count;
        end else if (state_r == CTC_PRE && we && i_trigger) begin
            post_left_r <= post_count_r;
        end else if (state_r == CTC_POST && we) begin
            post_left_r <= post_left_r - 1'b1;
        end
    end

    // Record addresses. Triggers outside CTC_PRE are not looked at.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rec_r <= '0;
        end else if (state_r == CTC_IDLE && i_start_capture) begin
            rec_r <= '0;
        end else begin
            if (we && waddr_r == CTC_ADDR_LAST) begin
                rec_r.wrapped <= 1'b1;
            end
            if (state_r == CTC_PRE && we && i_trigger) begin
                rec_r.trig_addr <= waddr_r;
            end
            if ((state_r == CTC_PRE && we && i_trigger &&
                 post_count_r == '0) ||
                (state_r == CTC_POST && we && post_left_r == CW'(1))) begin
                rec_r.end_addr <= waddr_r;
                rec_r.start_addr <= ctc_next(waddr_r);
            end
        end
    end

    // Host reads only while idle; a refused read is flagged instead.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_pend_r <= 1'b0;
            o_host_ack <= 1'b0;
            o_host_refused <= 1'b0;
            o_host_rdata <= '0;
        end else begin
            rd_pend_r <= i_host_rd && host_ok;
            o_host_refused <= i_host_rd && !host_ok;
            o_host_ack <= rd_pend_r;
            if (rd_pend_r) begin
                o_host_rdata <= rdata;
            end
        end
    end

    // DMA master: walks start to end so the stream is in time order,
    // which spares the host the unwrap done under the ordering.
    // Before the ring filled, the oldest point is at location zero.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            dma_addr_r <= CTC_ADDR_ZERO;
            dma_left_r <= '0;
            dma_pend_r <= 1'b0;
            dma_last_pend_r <= 1'b0;
        end else begin
            dma_pend_r <= dma_issue;
            if (state_r == CTC_IDLE && i_dma_start) begin
                dma_addr_r <= rec_r.wrapped ? rec_r.start_addr
                                            : CTC_ADDR_ZERO;
                dma_left_r <= rec_r.wrapped ? AW'(DEPTH)
                    : ctc_span(CTC_ADDR_ZERO, rec_r.end_addr) + 1'b1;
            end else if (dma_issue) begin
                dma_addr_r <= ctc_next(dma_addr_r);
                dma_left_r <= dma_left_r - 1'b1;
                dma_last_pend_r <= (dma_left_r == AW'(1));
            end
        end
    end

    // Output holding register; data stands until taken.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            dma_have_r <= 1'b0;
            o_dma_data <= '0;
            o_dma_last <= 1'b0;
        end else if (dma_pend_r) begin
            dma_have_r <= 1'b1;
            o_dma_data <= rdata;
            o_dma_last <= dma_last_pend_r;
        end else if (dma_have_r && i_dma_ready) begin
            dma_have_r <= 1'b0;
            o_dma_last <= 1'b0;
        end
    end

    assign o_dma_valid = dma_have_r;
    assign o_dma_busy = (state_r == CTC_XFER);
    assign o_busy = (state_r == CTC_PRE) || (state_r == CTC_POST);
    assign o_triggered = (state_r == CTC_POST);
    assign o_record = rec_r;
endmodule : ctc_capture

// ===== testbench/ctc_capture_props.sv
/* Port checker for ctc_capture.
   Assumes it is bound into ctc_capture by the bind below. */
`timescale 1ns/1ns
module ctc_capture_props
    import ctc_pkg::*;
#(
    parameter int DEPTH = CTC_DEPTH,
    parameter int CW = CTC_CW
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start_capture,
    input wire logic [CW-1:0] i_post_count,
    input wire ctc_sample_t i_sample,
    input wire logic i_trigger,
    input wire logic i_host_rd,
    input wire logic o_host_ack,
    input wire logic o_host_refused,
    input wire logic i_dma_start,
    input wire logic o_dma_busy,
    input wire logic o_busy,
    input wire logic o_triggered,
    input wire ctc_record_t o_record
);
    logic idle;
    logic go;
    logic hit;
    logic [CTC_AW-1:0] wa_r;
    logic [CW-1:0] n_r;
    logic [CW-1:0] pc_r;
    assign idle = !o_busy && !o_dma_busy;
    assign go = idle && i_start_capture;
    assign hit = o_busy && !o_triggered && i_sample.valid && i_trigger;
    // Shadow write pointer and post count, rebuilt from port activity.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wa_r <= '0;
            n_r <= '0;
            pc_r <= '0;
        end else if (go) begin
            wa_r <= '0;
            n_r <= i_post_count;
            pc_r <= '0;
        end else if (o_busy && i_sample.valid) begin
            wa_r <= (wa_r == CTC_AW'(DEPTH - 1)) ? '0 : wa_r + 1'b1;
            pc_r <= o_triggered ? pc_r + 1'b1 : pc_r;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_cmd; go |=> o_busy; endproperty
    property p_refuse; i_host_rd && o_busy |=> o_host_refused; endproperty
    property p_open; i_host_rd && idle |-> ##2 o_host_ack; endproperty
    property p_pre;
        o_busy && !o_triggered && !(i_sample.valid && i_trigger) |=> o_busy;
    endproperty
    property p_trig; hit |=> o_record.trig_addr == $past(wa_r); endproperty
    property p_late;
        o_busy && o_triggered |=> $stable(o_record.trig_addr);
    endproperty
    property p_count; $fell(o_busy) |-> pc_r == n_r; endproperty
    property p_end;
        $fell(o_busy) |-> o_record.start_addr == wa_r && o_record.end_addr ==
            (wa_r == '0 ? CTC_AW'(DEPTH - 1) : wa_r - 1'b1);
    endproperty
    property p_dma;
        idle && i_dma_start && !i_start_capture |=> o_dma_busy;
    endproperty
    a_cmd: assert property (p_cmd) else $error("no busy");
    a_refuse: assert property (p_refuse) else $error("no refuse");
    a_open: assert property (p_open) else $error("no ack");
    a_pre: assert property (p_pre) else $error("early stop");
    a_trig: assert property (p_trig) else $error("trig addr");
    a_late: assert property (p_late) else $error("retrigger");
    a_count: assert property (p_count) else $error("post count");
    a_end: assert property (p_end) else $error("end addr");
    a_dma: assert property (p_dma) else $error("no dma");
    c_wrap: cover property (o_record.wrapped);
    c_late: cover property (o_triggered && i_trigger);
    c_refuse: cover property (o_host_refused);
endmodule : ctc_capture_props

bind ctc_capture ctc_capture_props #(.DEPTH(DEPTH), .CW(CW)) ctc_props_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_start_capture(i_start_capture),
    .i_post_count(i_post_count), .i_sample(i_sample), .i_trigger(i_trigger),
    .i_host_rd(i_host_rd), .o_host_ack(o_host_ack),
    .o_host_refused(o_host_refused), .i_dma_start(i_dma_start),
    .o_dma_busy(o_dma_busy), .o_busy(o_busy), .o_triggered(o_triggered),
    .o_record(o_record));

// ===== testbench/ctc_host_model.sv
/* Host side DMA sink that tallies the words it accepts.
   Assumes the bench pulses i_clr before each transfer. */
`timescale 1ns/1ns
module ctc_host_model
    import ctc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_valid,
    input wire logic [CTC_DW-1:0] i_data,
    input wire logic i_last,
    output logic o_ready,
    output int o_words,
    output logic [CTC_DW-1:0] o_first,
    output logic [CTC_DW-1:0] o_final,
    output logic o_last_ok
);
    initial o_ready = 1'b0;
    initial o_words = 0;
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            if (o_words == 0) o_first <= i_data;
            o_final <= i_data;
            o_last_ok <= i_last;
            o_words <= o_words + 1;
        end
        if (i_clr) o_words <= 0;
        // Stalling every other cycle exercises the hold of valid data.
        o_ready <= #1 !o_ready;
    end
endmodule : ctc_host_model

// ===== testbench/circular_trigger_capture_tb_top.sv
/* Self-checking bench for ctc_capture with a DMA host model.
   Assumes the port checker is bound in from its own file. */
`timescale 1ns/1ns
module circular_trigger_capture_tb_top
    import ctc_pkg::*;
;
    logic i_clk = 0, i_reset = 1, i_start_capture = 0, i_trigger = 0;
    logic i_host_rd = 0, i_dma_start = 0, clr = 0;
    logic [13:0] i_post_count = '0, i_host_addr = '0;
    ctc_sample_t i_sample = '0;
    logic o_host_ack, o_host_refused, o_dma_valid, o_dma_last, o_dma_busy;
    logic o_busy, o_triggered, rdy, last_ok;
    logic [15:0] o_host_rdata, o_dma_data, first, final_w;
    ctc_record_t o_record;
    int error_cnt = 0, checks_done = 0, cyc = 0, words;
    // pre, post, trig, end, start, wrapped, dma words, first, last
    int rows [4][9] = '{'{0, 0, 0, 0, 1, 0, 1, 0, 0},
        '{5, 3, 5, 8, 9, 0, 9, 0, 8}, '{9998, 1, 9998, 9999, 0, 1, 0, 0, 0},
        '{10003, 2, 3, 5, 6, 1, 10000, 6, 10005}};
    ctc_capture ctc_capture_inst (.i_clk(i_clk), .i_reset(i_reset),
        .i_start_capture(i_start_capture), .i_post_count(i_post_count),
        .i_sample(i_sample), .i_trigger(i_trigger), .i_host_rd(i_host_rd),
        .i_host_addr(i_host_addr), .o_host_ack(o_host_ack),
        .o_host_refused(o_host_refused), .o_host_rdata(o_host_rdata),
        .i_dma_start(i_dma_start), .i_dma_ready(rdy),
        .o_dma_valid(o_dma_valid), .o_dma_data(o_dma_data),
        .o_dma_last(o_dma_last), .o_dma_busy(o_dma_busy), .o_busy(o_busy),
        .o_triggered(o_triggered), .o_record(o_record));
    ctc_host_model ctc_host_model_inst (.i_clk(i_clk), .i_clr(clr),
        .i_valid(o_dma_valid), .i_data(o_dma_data), .i_last(o_dma_last),
        .o_ready(rdy), .o_words(words), .o_first(first), .o_final(final_w),
        .o_last_ok(last_ok));
    initial forever #5 i_clk = ~i_clk;
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [15:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic cap(input int pre, post);
        int i;
        i = 0;
        i_post_count = post[13:0];
        i_start_capture = 1;
        tick;
        i_start_capture = 0;
        chk("busy", 1, o_busy);
        while (o_busy === 1'b1 && i < 20000) begin
            if (i == 2) chk("refused", 1, o_host_refused);
            if (i == pre + 1) chk("triggered", 1, o_triggered);
            i_sample = {1'b1, i[15:0]};
            i_trigger = (i == pre || i == pre + 2);
            i_host_rd = (i == 1);
            tick;
            i++;
        end
        i_sample = '0;
        i_trigger = 0;
        i_host_rd = 0;
        chk("stored", pre + post + 1, i);
    endtask : cap
    task automatic dma(input int n, f, l);
        int k;
        k = 0;
        clr = 1;
        i_dma_start = 1;
        tick;
        clr = 0;
        i_dma_start = 0;
        while (o_dma_busy === 1'b1 && k < 50000) begin
            tick;
            k++;
        end
        tick;
        chk("words", n, words);
        chk("first", f, first);
        chk("final", l, final_w);
        chk("lastflag", 1, last_ok);
    endtask : dma
    task automatic rd(input logic [13:0] a, input logic [15:0] d);
        i_host_addr = a;
        i_host_rd = 1;
        tick;
        i_host_rd = 0;
        tick;
        chk("ack", 1, o_host_ack);
        chk("rdata", d, o_host_rdata);
    endtask : rd
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_reset = 0;
        chk("rst_busy", 0, o_busy);
        for (int r = 0; r < 4; r++) begin
            cap(rows[r][0], rows[r][1]);
            chk("trig", rows[r][2], o_record.trig_addr);
            chk("end", rows[r][3], o_record.end_addr);
            chk("start", rows[r][4], o_record.start_addr);
            chk("wrap", rows[r][5], o_record.wrapped);
            if (rows[r][6] != 0) begin
                dma(rows[r][6], rows[r][7], rows[r][8]);
            end
            $display("row %0d done", r);
        end
        rd(14'h0007, 16'h0007);
        rd(14'h0002, 16'h2712);
        i_start_capture = 1;
        tick;
        i_start_capture = 0;
        i_reset = 1;
        tick;
        chk("mid_reset", 0, o_busy);
        i_reset = 0;
        tick;
        chk("rel_busy", 0, o_busy);
        chk("rel_dma", 0, o_dma_valid);
        tick;
        chk("rel_trig", 0, o_triggered);
        // A capture cut by reset must leave the block able to start again.
        cap(2, 1);
        chk("rst_trig", 2, o_record.trig_addr);
        chk("rst_end", 3, o_record.end_addr);
        chk("rst_start", 4, o_record.start_addr);
        chk("rst_wrap", 0, o_record.wrapped);
        $display("reads and reset done");
        results();
    end
endmodule : circular_trigger_capture_tb_top
